// *** dmx_adc_model.sv ***
// Purpose: Converter source model driving the data-ready clock and words
// Assumes: Link clock period 80 ns, unrelated in phase to aclk
// Notes:   Clock stands still between bursts; idle data is the last word inverted
`timescale 1ns/1ps
module dmx_adc_model (
  // Link pins
  output logic       sampling_clock_in,
  output logic [9:0] word_in
);
  initial
  begin
    sampling_clock_in = 1'b0;
    word_in           = 10'h000;
  end
  // ----
  // Burst of n words, one per rising edge or one per edge
  // ----
  task automatic send(input int n, input logic [9:0] base, input bit half);
    for (int i = 0; i < n; i++)
    begin
      // One word per 80 ns, or per 40 ns at half rate, keeps far below the word-rate limit
      word_in = base + 10'(i);
      if (half)
      begin
        #21.3 sampling_clock_in = ~sampling_clock_in;
        #18.7;
      end
      else
      begin
        #21.3 sampling_clock_in = 1'b1;
        #40 sampling_clock_in = 1'b0;
        #18.7;
      end
    end
    // Released data lines no longer show the last word
    word_in = ~word_in;
  endtask
endmodule

// *** dmx_demux.sv ***
// Purpose: Demultiplex converter words onto four or eight output ports
// Assumes: Pins sampled by aclk; each input word lasts at least 4 aclk
// Notes:   Registers over AXI4-Lite; strobe is a differential pair
`timescale 1ns/1ps
module dmx_demux #(
  parameter int DATA_W = 10,
  parameter int PORTS  = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Converter side pins
  input  wire logic              sampling_clock_in,
  input  wire logic [DATA_W-1:0] word_in,
  input  wire logic              async_master_reset,
  input  wire logic              sync_realign_in,
  // Output ports
  output logic [DATA_W-1:0]      port_a_data,
  output logic [DATA_W-1:0]      port_b_data,
  output logic [DATA_W-1:0]      port_c_data,
  output logic [DATA_W-1:0]      port_d_data,
  output logic [DATA_W-1:0]      port_e_data,
  output logic [DATA_W-1:0]      port_f_data,
  output logic [DATA_W-1:0]      port_g_data,
  output logic [DATA_W-1:0]      port_h_data,
  output logic                   output_word_strobe_p,
  output logic                   output_word_strobe_n
);
  if (DATA_W != 10 || PORTS != 8)
  begin : g_bad_cfg
    $error("dmx_demux serves only 10-bit words on 8 ports");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W+2:0] pins_s;
  logic [DATA_W-1:0] data_s;
  logic              clk_s;
  logic              amr_s;
  logic              rea_s;
  logic              clk_prev_reg;
  logic              rea_prev_reg;

  dmx_sync2 #(.W(DATA_W+3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_async ({sync_realign_in, async_master_reset, sampling_clock_in, word_in}),
    .d_sync  (pins_s)
  );

  assign data_s = pins_s[DATA_W-1:0];
  assign clk_s  = pins_s[DATA_W];
  assign amr_s  = pins_s[DATA_W+1];
  assign rea_s  = pins_s[DATA_W+2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_prev_reg <= 1'b0;
      rea_prev_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= clk_s;
      rea_prev_reg <= rea_s;
    end
  end

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic       ratio8;
  logic       wide;
  logic       halfclk;
  logic [2:0] last_idx;
  logic [2:0] half_idx;

  assign ratio8   = ctrl_reg[dmx_pkg::CTRL_RATIO8];
  assign wide     = ctrl_reg[dmx_pkg::CTRL_WIDE];
  assign halfclk  = ctrl_reg[dmx_pkg::CTRL_HALFCLK];
  assign last_idx = ratio8 ? dmx_pkg::LAST_R8 : dmx_pkg::LAST_R4;
  assign half_idx = ratio8 ? dmx_pkg::HALF_R8 : dmx_pkg::HALF_R4;

  // ---------------------------------------------------------------
  // Word events and port selection
  // ---------------------------------------------------------------
  logic              word_evt;
  logic              run_evt;
  logic [2:0]        cnt_reg;
  logic [2:0]        idx;
  logic              realign_pend_reg;
  logic              aligned_reg;
  logic [DATA_W-1:0] word;

  // Full rate uses rising edges, half rate uses both edges
  assign word_evt = (clk_s & ~clk_prev_reg) | (halfclk & ~clk_s & clk_prev_reg);
  assign run_evt  = word_evt & ~amr_s;
  // Nap: upper bits held at zero for narrow words
  assign word = {wide ? data_s[DATA_W-1:8] : 2'b00, data_s[7:0]};
  // Pending re-alignment forces the internal counter reset for this word
  assign idx = realign_pend_reg ? dmx_pkg::IDX_START : cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= dmx_pkg::IDX_START;
    else if (amr_s)
      cnt_reg <= dmx_pkg::IDX_START;
    else if (word_evt)
      cnt_reg <= (idx >= last_idx) ? dmx_pkg::IDX_START : idx + dmx_pkg::IDX_ONE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      realign_pend_reg <= 1'b0;
    else if (rea_s && !rea_prev_reg)
      realign_pend_reg <= 1'b1;
    else if (run_evt)
      realign_pend_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aligned_reg <= 1'b0;
    else if (run_evt && realign_pend_reg)
      aligned_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Slots and output ports
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] slot_reg [PORTS];
  logic [DATA_W-1:0] port_q   [PORTS];
  logic              strobe_reg;
  logic              load;

  assign load = run_evt & (idx == last_idx);

  for (genvar i = 0; i < PORTS; i++)
  begin : g_port
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        slot_reg[i] <= '0;
      else if (run_evt && idx == 3'(i))
        slot_reg[i] <= word;
    end

    // Frozen while master reset is high; all ports load together
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        port_q[i] <= '0;
      else if (load)
        port_q[i] <= (idx == 3'(i)) ? word : slot_reg[i];
    end
  end

  // Rises with the group load, falls half a group later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      strobe_reg <= 1'b0;
    else if (load)
      strobe_reg <= 1'b1;
    else if (run_evt && idx == half_idx)
      strobe_reg <= 1'b0;
  end

  assign port_a_data          = port_q[0];
  assign port_b_data          = port_q[1];
  assign port_c_data          = port_q[2];
  assign port_d_data          = port_q[3];
  assign port_e_data          = port_q[4];
  assign port_f_data          = port_q[5];
  assign port_g_data          = port_q[6];
  assign port_h_data          = port_q[7];
  assign output_word_strobe_p = strobe_reg;
  assign output_word_strobe_n = ~strobe_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [3:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic [31:0] stat_word;

  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end
    else if (aw_hold_reg && w_hold_reg)
      aw_hold_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb0_reg <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end
    else if (aw_hold_reg && w_hold_reg)
      w_hold_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dmx_pkg::RESP_OKAY;
    end
    else if (aw_hold_reg && w_hold_reg)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == dmx_pkg::CTRL_OFS || awaddr_reg == dmx_pkg::STAT_OFS)
                      ? dmx_pkg::RESP_OKAY : dmx_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= dmx_pkg::CTRL_RESET;
    else if (aw_hold_reg && w_hold_reg && wstrb0_reg && awaddr_reg == dmx_pkg::CTRL_OFS)
      ctrl_reg <= wdata_reg[2:0];
  end

  assign stat_word = {25'h0000000, cnt_reg, 2'b00, amr_s, aligned_reg};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dmx_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= dmx_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dmx_pkg::CTRL_OFS: s_axi_rdata <= {29'h0000000, ctrl_reg};
        dmx_pkg::STAT_OFS: s_axi_rdata <= stat_word;
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= dmx_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Marks the first word event after a master reset
  logic amr_first_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      amr_first_reg <= 1'b0;
    else if (amr_s)
      amr_first_reg <= 1'b1;
    else if (run_evt)
      amr_first_reg <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CNT_RANGE: assert property (run_evt |=> cnt_reg <= $past(last_idx))
    else $error("port counter beyond ratio");
  AST_EVT_SRC: assert property (word_evt |-> clk_s != clk_prev_reg && (halfclk || clk_s))
    else $error("word event without a valid sampling edge");
  AST_NAP: assert property (load && !wide |=> port_q[0][9:8] == 2'b00)
    else $error("napped bits not zero");
  AST_AMR_CNT: assert property (amr_s |=> cnt_reg == 3'h0)
    else $error("master reset did not clear port selection");
  AST_FREEZE: assert property (amr_s |=> $stable(strobe_reg) && $stable(port_q[0]))
    else $error("outputs moved during master reset");
  AST_FIRST_A: assert property (run_evt && amr_first_reg |-> idx == 3'h0)
    else $error("first word after release not on port A");
  AST_REALIGN: assert property (run_evt && realign_pend_reg |=> cnt_reg == 3'h1)
    else $error("re-alignment did not load counter");
  AST_ALIGNED_QUIET: assert property (run_evt && realign_pend_reg && cnt_reg == 3'h0
                                      |=> cnt_reg == 3'h1 && $stable(port_q[0]) && $stable(strobe_reg))
    else $error("re-alignment moved an aligned counter");
  AST_ROTATE: assert property (run_evt && !realign_pend_reg && cnt_reg < last_idx
                               |=> cnt_reg == $past(cnt_reg) + 3'h1)
    else $error("port rotation skipped");
  AST_STROBE_RISE: assert property (load |=> strobe_reg && port_q[0] == $past(slot_reg[0]))
    else $error("strobe not raised at group load");
  AST_STROBE_FALL: assert property (run_evt && idx == half_idx && !load |=> !strobe_reg)
    else $error("strobe not lowered at half group");
  AST_DIFF: assert property (output_word_strobe_n == !output_word_strobe_p)
    else $error("strobe pair not complementary");
  AST_LATENCY: assert property (run_evt && idx == last_idx |=> strobe_reg &&
                                ($past(ratio8) ? port_q[7] : port_q[3]) == $past(word))
    else $error("group load beyond pipeline bound");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  COV_LOAD8: cover property (load && ratio8);
  COV_LOAD4: cover property (load && !ratio8);
  COV_MISALIGN: cover property (run_evt && realign_pend_reg && cnt_reg != 3'h0);
  COV_AMR_REL: cover property ($fell(amr_s));
endmodule

// *** dmx_pkg.sv ***
// Purpose: Shared constants for the converter word demultiplexer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses
package dmx_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  CTRL_OFS     = 4'h0;
  localparam logic [3:0]  STAT_OFS     = 4'h4;
  // Control fields
  localparam int          CTRL_RATIO8  = 0;
  localparam int          CTRL_WIDE    = 1;
  localparam int          CTRL_HALFCLK = 2;
  localparam logic [2:0]  CTRL_RESET   = 3'h3;
  // Status fields
  localparam int          STAT_ALIGNED = 0;
  localparam int          STAT_INRST   = 1;
  localparam int          STAT_IDX_LO  = 4;
  // ---------------------------------------------------------------
  // Port sequencing
  // ---------------------------------------------------------------
  localparam logic [2:0]  LAST_R4      = 3'h3;
  localparam logic [2:0]  LAST_R8      = 3'h7;
  localparam logic [2:0]  HALF_R4      = 3'h1;
  localparam logic [2:0]  HALF_R8      = 3'h3;
  localparam logic [2:0]  IDX_START    = 3'h0;
  localparam logic [2:0]  IDX_ONE      = 3'h1;
  // ---------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// *** dmx_sync2.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dmx_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] d_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      d_sync   <= '0;
    end
    else
    begin
      meta_reg <= d_async;
      d_sync   <= meta_reg;
    end
  end
endmodule

// *** test_dmx_demux.sv ***
// Purpose: Self-checking bench for the converter word demultiplexer
// Assumes: Source model drives the link pins; bench drives AXI4-Lite
// Notes:   Expected port words are derived from each burst base
`timescale 1ns/1ps
module test_dmx_demux;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, amr, realign, stb_p, stb_n;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        sclk;
  logic [9:0]  word;
  logic [9:0]  prt [0:7];
  int          fails, samples_checked;

  dmx_adc_model u_adc (.sampling_clock_in(sclk), .word_in(word));
  dmx_demux u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sampling_clock_in(sclk), .word_in(word), .async_master_reset(amr),
    .sync_realign_in(realign),
    .port_a_data(prt[0]), .port_b_data(prt[1]), .port_c_data(prt[2]),
    .port_d_data(prt[3]), .port_e_data(prt[4]), .port_f_data(prt[5]),
    .port_g_data(prt[6]), .port_h_data(prt[7]),
    .output_word_strobe_p(stb_p), .output_word_strobe_n(stb_n)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ----
  // Checking and closing
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout();
    fails++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end_of_test();
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ----
  // AXI4-Lite master
  // ----
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] rs);
    int n;
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (n == 64) timeout();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rs);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    dat = rdata;
    rs = rresp;
    if (n == 64) timeout();
  endtask
  // ----
  // Link helpers
  // ----
  task automatic burst(input int n, input logic [9:0] base, input bit half);
    u_adc.send(n, base, half);
    wait_clk(4);
  endtask
  task automatic chk_grp(input int n, input logic [9:0] base, input logic [9:0] mask);
    for (int i = 0; i < n; i++)
      chk({22'h0, prt[i]}, {22'h0, (base + 10'(i)) & mask});
  endtask
  task automatic pulse_realign();
    realign <= 1'b1;
    wait_clk(6);
    realign <= 1'b0;
    wait_clk(6);
  endtask

  initial
  begin
    fails = 0;
    samples_checked = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, amr, realign} <= 8'h00;
    {awaddr, araddr, wdata} <= 40'h0;
    wait_clk(12);
    aresetn <= 1'b1;
    wait_clk(2);
    axi_rd(dmx_pkg::CTRL_OFS, d, r);
    chk(d, {29'h0, dmx_pkg::CTRL_RESET});
    chk({30'h0, r}, {30'h0, dmx_pkg::RESP_OKAY});
    axi_wr(4'h8, 32'hff, r);
    chk({30'h0, r}, {30'h0, dmx_pkg::RESP_SLVERR});
    axi_rd(4'h8, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, dmx_pkg::RESP_SLVERR});
    axi_wr(dmx_pkg::STAT_OFS, 32'hff, r);
    chk({30'h0, r}, {30'h0, dmx_pkg::RESP_OKAY});
    $display("test registers done");
    amr <= 1'b1;
    wait_clk(8);
    amr <= 1'b0;
    wait_clk(4);
    burst(8, 10'h3a0, 1'b0);
    chk_grp(8, 10'h3a0, 10'h3ff);
    chk({30'h0, stb_p, stb_n}, 32'h2);
    $display("test start done");
    burst(4, 10'h100, 1'b0);
    chk({30'h0, stb_p, stb_n}, 32'h1);
    chk_grp(1, 10'h3a0, 10'h3ff);
    burst(4, 10'h104, 1'b0);
    chk_grp(8, 10'h100, 10'h3ff);
    chk({30'h0, stb_p, stb_n}, 32'h2);
    $display("test strobe done");
    burst(3, 10'h200, 1'b0);
    amr <= 1'b1;
    wait_clk(20);
    chk_grp(8, 10'h100, 10'h3ff);
    chk({30'h0, stb_p, stb_n}, 32'h2);
    amr <= 1'b0;
    wait_clk(4);
    burst(8, 10'h210, 1'b0);
    chk_grp(8, 10'h210, 10'h3ff);
    $display("test master reset done");
    axi_wr(dmx_pkg::CTRL_OFS, 32'h0, r);
    axi_rd(dmx_pkg::CTRL_OFS, d, r);
    chk(d & 32'h7, 32'h0);
    burst(4, 10'h3f0, 1'b0);
    chk_grp(4, 10'h3f0, 10'h0ff);
    $display("test narrow four-port done");
    wait_clk(1);
    axi_wr(dmx_pkg::CTRL_OFS, 32'h6, r);
    burst(4, 10'h2c0, 1'b1);
    chk_grp(4, 10'h2c0, 10'h3ff);
    $display("test half rate done");
    wait_clk(1);
    axi_wr(dmx_pkg::CTRL_OFS, 32'h3, r);
    pulse_realign();
    burst(8, 10'h050, 1'b0);
    chk_grp(8, 10'h050, 10'h3ff);
    burst(5, 10'h060, 1'b0);
    wait_clk(1);
    pulse_realign();
    burst(8, 10'h070, 1'b0);
    chk_grp(8, 10'h070, 10'h3ff);
    wait_clk(1);
    pulse_realign();
    burst(8, 10'h080, 1'b0);
    chk_grp(8, 10'h080, 10'h3ff);
    axi_rd(dmx_pkg::STAT_OFS, d, r);
    chk(d & 32'h71, 32'h1);
    $display("test realign done");
    end_of_test();
  end
endmodule
